// file: src/mpf_pkg.sv
// Shared constants, enumerations and carrier structs of the value formatter.
package mpf_pkg;
	localparam int WORD_W = 16;
	localparam int RAW_W = 32;
	localparam int ACC_W = 48;
	// Scaled values outside this band are saturated on read.
	localparam logic signed [ACC_W-1:0] LIM_HI = 48'sh00000000_4e20;
	localparam logic signed [ACC_W-1:0] LIM_LO = -48'sh00000000_4e20;
	localparam logic signed [ACC_W-1:0] INT32_MAX = 48'sh0000_7fffffff;
	localparam logic signed [ACC_W-1:0] INT32_MIN = -48'sh0000_80000000;
	localparam logic [15:0] SAT_HI = 16'h7fff;
	localparam logic [15:0] SAT_LO = 16'h8000;
	localparam logic [15:0] INVALID_CODE = 16'h56ce;
	localparam logic [15:0] TXT_BASE = 16'h7530;
	localparam logic [7:0] SPLIT_BIAS = 8'h80;
	// Decimal offset digits; internal numerics carry three implied decimals.
	localparam logic [3:0] DIGIT_MUL_MAX = 4'h5;
	localparam logic [3:0] DIGIT_PCT = 4'h9;
	localparam logic [3:0] STEPS_UNITS = 4'h3;
	localparam logic [3:0] STEPS_PCT = 4'h1;
	localparam logic [3:0] STEPS_IMPL = 4'h8;
	// Modbus function and exception codes.
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_READ_INPUT = 8'h04;
	localparam logic [7:0] FC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FC_WRITE_MANY = 8'h10;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_VALUE = 8'h03;

	typedef enum logic [3:0] {
		K_NUM = 4'h0, K_BITS = 4'h1, K_SPLIT = 4'h2, K_U32 = 4'h3,
		K_TEXT = 4'h4, K_RELAY = 4'h5, K_NOVAL = 4'h6, K_NOEXIST = 4'h7,
		K_UNSET = 4'h8, K_DASHED = 4'h9
	} mpf_kind_e;

	typedef enum logic [3:0] {
		TXT_OFF = 4'h0, TXT_ON = 4'h1, TXT_DASH = 4'h2, TXT_NOEXIST = 4'h3,
		TXT_ERR = 4'h4, TXT_ERR1 = 4'h5, TXT_OPEN = 4'h6, TXT_SHORT = 4'h7,
		TXT_PASS = 4'h8, TXT_FAIL = 4'h9, TXT_HOLD = 4'ha, TXT_LO = 4'hb,
		TXT_HI = 4'hc, TXT_DE = 4'hd, TXT_EN = 4'he, TXT_UNSET = 4'hf
	} mpf_txt_e;

	typedef enum logic [6:0] {
		RF_OFF = 7'h00, RF_LEVEL = 7'h01, RF_LOLO = 7'h02, RF_LO = 7'h03,
		RF_HI = 7'h04, RF_HIHI = 7'h05, RF_INB = 7'h06, RF_OUTB = 7'h09,
		RF_RATE = 7'h0c, RF_TEMP = 7'h0f, RF_CABLE = 7'h10, RF_LOE = 7'h14,
		RF_TOTAL = 7'h16, RF_SAMPLER = 7'h17, RF_FIX_AST = 7'h19,
		RF_FIX_BKP = 7'h1a, RF_ALT_AST = 7'h1e, RF_ALT_BKP = 7'h1f,
		RF_SR_AST = 7'h23, RF_SR_BKP = 7'h24, RF_FIFO = 7'h28,
		RF_FLUSH = 7'h41, RF_COMM = 7'h42
	} mpf_relay_e;

	typedef enum logic [1:0] {
		MB_SILENT = 2'h0, MB_NORMAL = 2'h1, MB_EXCEPTION = 2'h2
	} mpf_mb_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_SCALE = 2'h1, ST_DONE = 2'h2
	} mpf_state_e;

	typedef struct packed {
		logic wr;
		mpf_kind_e kind;
		logic [3:0] digit;
		logic pct_ok;
		logic word_sel;
		logic [RAW_W-1:0] raw;
		logic [RAW_W-1:0] pct;
		logic [WORD_W-1:0] word;
	} mpf_req_s;

	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic [RAW_W-1:0] value;
		logic err;
	} mpf_rsp_s;

	typedef struct packed {
		logic frame_ok;
		logic [7:0] func;
		logic addr_ok;
		logic value_ok;
	} mpf_mb_req_s;

	typedef struct packed {
		mpf_mb_e kind;
		logic [7:0] code;
	} mpf_mb_ans_s;
endpackage : mpf_pkg

// file: src/mpf_dec_scaler.sv
// Sequential decimal scaler: one multiply or divide by ten per clock.
`timescale 1ns/1ps
`default_nettype none
module mpf_dec_scaler #(
	parameter int W = 48
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic mul_i,
	input wire logic [3:0] steps_i,
	input wire logic signed [W-1:0] value_i,
	output logic done_o,
	output logic signed [W-1:0] acc_o
);
	import mpf_pkg::*;
	logic busy_reg;
	logic mul_reg;
	logic [3:0] cnt_reg;
	logic signed [W-1:0] acc_reg;
	logic signed [W-1:0] step_w;

	// Shifts replace a multiplier; divide truncates toward zero like the host.
	assign step_w = mul_reg ? (acc_reg <<< 3) + (acc_reg <<< 1)
		: acc_reg / W'(10);
	assign done_o = busy_reg && (cnt_reg == 4'h0);
	assign acc_o = acc_reg;

	// A start always wins, so a stale run can never leak into a new one.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			busy_reg <= 1'b0;
			mul_reg <= 1'b0;
			cnt_reg <= 4'h0;
			acc_reg <= '0;
		end else if (start_i) begin
			busy_reg <= 1'b1;
			mul_reg <= mul_i;
			cnt_reg <= steps_i;
			acc_reg <= value_i;
		end else if (done_o) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 4'h1;
			acc_reg <= step_w;
		end
	end
endmodule : mpf_dec_scaler
`default_nettype wire

// file: src/mpf_formatter.sv
// Parameter value formatter and Modbus answer classifier.
// Functional notes
// RULE1: every value maps to one 16-bit word
// RULE2: requester picks units or percent, decimals
// RULE3: scaled value valid within plus/minus twenty thousand
// RULE4: above gives 32767, below gives -32768
// RULE5: no percent or no meaning gives 22222
// RULE6: bit 1 is LSB, bit 16 MSB
// RULE7: UINT32 lower register holds MSW by default
// RULE8: word-order setting swaps the two halves
// RULE9: split write word is (xx+128)*256+(yy+128)
// RULE10: split read: each byte minus 128
// RULE11: text messages return fixed codes 30000-30014
// RULE12: missing gives 30003, dashes give 30002
// RULE13: never-set parameter gives 30015
// RULE14: relay function codes, small variant
// RULE15: extra relay codes in large variant
// RULE16: corrupt: silent, normal: echo, error: exception
// RULE17: disallowed function code gives exception 01
// RULE18: disallowed data address gives exception 02
// RULE19: disallowed data value gives exception 03
// RULE20: host retries saturated reads with fewer decimals
// RULE21: offset digit selects shift, decimals or percent
// RULE22: scaling happens before the range check
`timescale 1ns/1ps
`default_nettype none
module mpf_formatter #(
	parameter bit LARGE_RELAY = 1'b1
) (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire mpf_pkg::mpf_req_s req_i,
	input wire logic word_order_swap_i,
	output logic rsp_valid_o,
	output mpf_pkg::mpf_rsp_s rsp_o,
	input wire logic mb_valid_i,
	input wire mpf_pkg::mpf_mb_req_s mb_req_i,
	output logic mb_ans_valid_o,
	output mpf_pkg::mpf_mb_ans_s mb_ans_o
);
	import mpf_pkg::*;

	// Number of ten-steps for an offset digit against the milli-unit store.
	function automatic logic [3:0] steps_of(input logic [3:0] d);
		logic [3:0] s;
		s = STEPS_UNITS;
		if (d == DIGIT_PCT)
			s = STEPS_PCT;
		else if (d > DIGIT_MUL_MAX)
			s = STEPS_IMPL - d;
		else
			s = STEPS_UNITS + d;
		return s;
	endfunction : steps_of

	// Relay codes legal for the chosen variant.
	function automatic logic relay_ok(input logic [15:0] c, input logic lg);
		logic ok;
		ok = 1'b0;
		if (c[15:7] == 9'h000) begin
			case (mpf_relay_e'(c[6:0]))
				RF_OFF, RF_LEVEL, RF_LOLO, RF_LO, RF_HI, RF_HIHI, RF_LOE,
				RF_CABLE, RF_FIX_AST, RF_ALT_AST, RF_COMM: ok = 1'b1;
				RF_INB, RF_OUTB, RF_RATE, RF_TEMP, RF_TOTAL, RF_SAMPLER,
				RF_FIX_BKP, RF_ALT_BKP, RF_SR_AST, RF_SR_BKP, RF_FIFO,
				RF_FLUSH: ok = lg;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : relay_ok

	mpf_state_e state_reg;
	mpf_state_e state_next;
	mpf_req_s req_reg;
	mpf_rsp_s rsp_reg;
	mpf_rsp_s rsp_next;
	mpf_rsp_s fast_w;
	mpf_rsp_s slow_w;
	mpf_mb_ans_s mb_reg;
	mpf_mb_ans_s mb_next;
	logic mb_vld_reg;
	logic accept;
	logic is_num;
	logic num_bad;
	logic msw_sel;
	logic sc_done;
	logic signed [ACC_W-1:0] sc_src;
	logic signed [ACC_W-1:0] sc_acc;
	logic [15:0] txt_off;
	logic func_ok;

	// Request handshake and the decode of the incoming request.
	assign req_ready_o = (state_reg == ST_IDLE);
	assign accept = req_valid_i && req_ready_o;
	assign is_num = (req_i.kind == K_NUM);
	assign num_bad = (req_i.digit > DIGIT_PCT) ||
		((req_i.digit == DIGIT_PCT) && !req_i.pct_ok); // [RULE5]
	assign msw_sel = ~(req_i.word_sel ^ word_order_swap_i); // [RULE7] [RULE8]
	assign txt_off = req_i.word - TXT_BASE;

	// Scaler source: host word on write, percent or unit store on read.
	assign sc_src = req_i.wr ? ACC_W'(signed'(req_i.word))
		: (req_i.digit == DIGIT_PCT) ? ACC_W'(signed'(req_i.pct))
		: ACC_W'(signed'(req_i.raw)); // [RULE2]

	mpf_dec_scaler #(
		.W(ACC_W)
	) u_scaler (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(accept && is_num && !num_bad),
		.mul_i(req_i.wr),
		.steps_i(steps_of(req_i.digit)), // [RULE21]
		.value_i(sc_src),
		.done_o(sc_done),
		.acc_o(sc_acc)
	);

	// One-cycle conversions for everything that needs no decimal scaling.
	always_comb begin
		fast_w.word = INVALID_CODE;
		fast_w.value = req_i.raw;
		fast_w.err = req_i.wr;
		case (req_i.kind)
			K_NUM: begin
				fast_w.word = INVALID_CODE; // [RULE5]
			end
			K_BITS: begin
				fast_w.word = req_i.raw[15:0]; // [RULE6]
				fast_w.value = {16'h0000, req_i.word};
				fast_w.err = 1'b0;
			end
			K_SPLIT: begin
				fast_w.word = {req_i.raw[15:8] + SPLIT_BIAS,
					req_i.raw[7:0] + SPLIT_BIAS}; // [RULE9]
				fast_w.value = {16'h0000, req_i.word[15:8] - SPLIT_BIAS,
					req_i.word[7:0] - SPLIT_BIAS}; // [RULE10]
				fast_w.err = 1'b0;
			end
			K_U32: begin
				fast_w.word = msw_sel ? req_i.raw[31:16] : req_i.raw[15:0];
				fast_w.value = msw_sel ? {req_i.word, req_i.raw[15:0]}
					: {req_i.raw[31:16], req_i.word}; // [RULE7] [RULE8]
				fast_w.err = 1'b0;
			end
			K_TEXT: begin
				fast_w.word = TXT_BASE + {12'h000, req_i.raw[3:0]}; // [RULE11]
				if (txt_off <= {12'h000, TXT_EN}) begin
					fast_w.value = {16'h0000, txt_off};
					fast_w.err = 1'b0;
				end
			end
			K_RELAY: begin
				if (relay_ok(req_i.raw[15:0], LARGE_RELAY) &&
						(req_i.raw[31:16] == 16'h0000))
					fast_w.word = req_i.raw[15:0]; // [RULE14] [RULE15]
				if (relay_ok(req_i.word, LARGE_RELAY)) begin
					fast_w.value = {16'h0000, req_i.word};
					fast_w.err = 1'b0;
				end
			end
			K_NOVAL: fast_w.word = INVALID_CODE; // [RULE5]
			K_NOEXIST: fast_w.word = TXT_BASE + {12'h000, TXT_NOEXIST}; // [RULE12]
			K_DASHED: fast_w.word = TXT_BASE + {12'h000, TXT_DASH}; // [RULE12]
			K_UNSET: fast_w.word = TXT_BASE + {12'h000, TXT_UNSET}; // [RULE13]
			default: fast_w.word = INVALID_CODE;
		endcase
	end

	// Range check runs on the already scaled value, never the raw store.
	always_comb begin
		slow_w.word = sc_acc[15:0];
		slow_w.value = req_reg.raw;
		slow_w.err = 1'b0;
		if (!req_reg.wr) begin
			if (sc_acc > LIM_HI)
				slow_w.word = SAT_HI; // [RULE4] [RULE22]
			else if (sc_acc < LIM_LO)
				slow_w.word = SAT_LO; // [RULE4] [RULE22]
			else
				slow_w.word = sc_acc[15:0]; // [RULE3] [RULE1]
		end else begin
			slow_w.word = req_reg.word;
			// Huge offsets can overflow the store, so clip and flag them.
			if (sc_acc > INT32_MAX) begin
				slow_w.value = INT32_MAX[31:0];
				slow_w.err = 1'b1;
			end else if (sc_acc < INT32_MIN) begin
				slow_w.value = INT32_MIN[31:0];
				slow_w.err = 1'b1;
			end else begin
				slow_w.value = sc_acc[31:0]; // [RULE1]
			end
		end
	end

	// Sequencer: idle, optional scaling, then one answer cycle.
	always_comb begin
		state_next = state_reg;
		rsp_next = rsp_reg;
		case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					rsp_next = fast_w;
					state_next = (is_num && !num_bad) ? ST_SCALE : ST_DONE;
				end
			end
			ST_SCALE: begin
				if (sc_done) begin
					rsp_next = slow_w;
					state_next = ST_DONE;
				end
			end
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			rsp_reg <= '0;
			req_reg <= '0;
		end else begin
			state_reg <= state_next;
			rsp_reg <= rsp_next;
			if (accept)
				req_reg <= req_i;
		end
	end

	assign rsp_valid_o = (state_reg == ST_DONE);
	assign rsp_o = rsp_reg;

	// Slave answer: bad frames stay silent, then function, address, value.
	assign func_ok = (mb_req_i.func == FC_READ_HOLD) ||
		(mb_req_i.func == FC_READ_INPUT) ||
		(mb_req_i.func == FC_WRITE_ONE) || (mb_req_i.func == FC_WRITE_MANY);

	always_comb begin
		mb_next.kind = MB_NORMAL;
		mb_next.code = 8'h00;
		if (!mb_req_i.frame_ok) begin
			mb_next.kind = MB_SILENT; // [RULE16]
		end else if (!func_ok) begin
			mb_next.kind = MB_EXCEPTION;
			mb_next.code = EXC_FUNC; // [RULE17]
		end else if (!mb_req_i.addr_ok) begin
			mb_next.kind = MB_EXCEPTION;
			mb_next.code = EXC_ADDR; // [RULE18]
		end else if (!mb_req_i.value_ok) begin
			mb_next.kind = MB_EXCEPTION;
			mb_next.code = EXC_VALUE; // [RULE19]
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			mb_vld_reg <= 1'b0;
			mb_reg <= '0;
		end else begin
			mb_vld_reg <= mb_valid_i;
			if (mb_valid_i)
				mb_reg <= mb_next;
		end
	end

	assign mb_ans_valid_o = mb_vld_reg;
	assign mb_ans_o = mb_reg;

	// Checks on the conversion and answer paths.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	fast_answer_a: assert property (accept && !is_num |=> rsp_valid_o) // [RULE1]
		else $error("Unscaled request not answered next cycle.");
	scaled_answer_a: assert property (accept |-> ##[1:10] rsp_valid_o) // [RULE22]
		else $error("Scaled request not answered in time.");
	sat_high_a: assert property (state_reg == ST_SCALE && sc_done && // [RULE4]
		!req_reg.wr && sc_acc > LIM_HI |=> rsp_o.word == SAT_HI)
		else $error("High saturation code missing.");
	sat_low_a: assert property (state_reg == ST_SCALE && sc_done && // [RULE4]
		!req_reg.wr && sc_acc < LIM_LO |=> rsp_o.word == SAT_LO)
		else $error("Low saturation code missing.");
	in_range_a: assert property (state_reg == ST_SCALE && sc_done && // [RULE3]
		!req_reg.wr && sc_acc <= LIM_HI && sc_acc >= LIM_LO
		|=> rsp_o.word == $past(sc_acc[15:0]))
		else $error("In-range value altered.");
	no_percent_a: assert property (accept && is_num && !req_i.wr && // [RULE5]
		req_i.digit == DIGIT_PCT && !req_i.pct_ok
		|=> rsp_valid_o && rsp_o.word == INVALID_CODE)
		else $error("Percent refusal code missing.");
	word_order_a: assert property (accept && req_i.kind == K_U32 && // [RULE8]
		!req_i.wr && !req_i.word_sel |=> rsp_o.word == (word_order_swap_i ?
		req_reg.raw[15:0] : req_reg.raw[31:16]))
		else $error("Wrong half of 32-bit value.");
	split_pack_a: assert property (accept && req_i.kind == K_SPLIT && // [RULE9]
		!req_i.wr |=> rsp_o.word[15:8] == req_reg.raw[15:8] + SPLIT_BIAS)
		else $error("Split high byte not biased.");
	missing_code_a: assert property (accept && // [RULE12]
		req_i.kind == K_NOEXIST |=> rsp_o.word == TXT_BASE + 16'h0003)
		else $error("Missing-parameter code wrong.");
	bad_func_a: assert property (mb_valid_i && mb_req_i.frame_ok && // [RULE17]
		!func_ok |=> mb_ans_valid_o && mb_ans_o.code == EXC_FUNC)
		else $error("Illegal function not flagged.");
	silent_frame_a: assert property (mb_valid_i && // [RULE16]
		!mb_req_i.frame_ok |=> mb_ans_o.kind == MB_SILENT)
		else $error("Corrupt frame answered.");

	scaled_read_c: cover property (accept && is_num && !req_i.wr
		##[1:10] rsp_valid_o);
	saturate_c: cover property (state_reg == ST_SCALE && sc_done &&
		sc_acc > LIM_HI);
	swapped_c: cover property (accept && req_i.kind == K_U32 &&
		word_order_swap_i);
	exception_c: cover property (mb_vld_reg && mb_reg.kind == MB_EXCEPTION);
endmodule : mpf_formatter
`default_nettype wire

// file: sim/mpf_host_model.sv
// Host-side model that issues conversions and Modbus frames.
`timescale 1ns/1ps
`default_nettype none
module mpf_host_model (
	input wire logic core_clk_i,
	input wire logic req_ready_i,
	input wire logic rsp_valid_i,
	input wire mpf_pkg::mpf_rsp_s rsp_i,
	input wire logic mb_ans_valid_i,
	input wire mpf_pkg::mpf_mb_ans_s mb_ans_i,
	output logic req_valid_o,
	output mpf_pkg::mpf_req_s req_o,
	output logic word_order_swap_o,
	output logic mb_valid_o,
	output mpf_pkg::mpf_mb_req_s mb_req_o
);
	import mpf_pkg::*;
	// Idle level of every line the host owns.
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
		word_order_swap_o = 1'b0;
		mb_valid_o = 1'b0;
		mb_req_o = '0;
	end
	// Fields are inverted once taken, so a late look at them sees garbage.
	task automatic xfer(input mpf_req_s q, input logic sw,
		output mpf_rsp_s rs, output logic ok);
		int n;
		rs = '0;
		@(negedge core_clk_i);
		req_valid_o = 1'b1;
		req_o = q;
		word_order_swap_o = sw;
		n = 0;
		while (req_ready_i !== 1'b1 && n < 16) begin
			@(negedge core_clk_i);
			n++;
		end
		@(negedge core_clk_i);
		req_valid_o = 1'b0;
		req_o = ~q;
		ok = 1'b0;
		n = 0;
		while (ok == 1'b0 && n < 16) begin
			if (rsp_valid_i === 1'b1) begin
				rs = rsp_i;
				ok = 1'b1;
			end else begin
				@(negedge core_clk_i);
				n++;
			end
		end
	endtask : xfer
	// Frames go back to back; the caller stands on a falling edge.
	task automatic frame(input mpf_mb_req_s m, input logic last,
		output mpf_mb_ans_s a, output logic ok);
		mb_valid_o = 1'b1;
		mb_req_o = m;
		@(negedge core_clk_i);
		ok = mb_ans_valid_i;
		a = mb_ans_i;
		if (last) begin
			mb_valid_o = 1'b0;
			mb_req_o = ~m;
		end
	endtask : frame
endmodule : mpf_host_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the parameter value formatter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mpf_pkg::*;
	logic core_clk_i;
	logic sys_rst_i;
	logic req_valid;
	logic req_ready;
	logic rsp_valid;
	logic swap;
	logic mb_valid;
	logic mb_ans_valid;
	logic ok;
	mpf_req_s req;
	mpf_rsp_s rsp;
	mpf_rsp_s rsp_small;
	mpf_rsp_s rs;
	mpf_mb_req_s mb_req;
	mpf_mb_ans_s mb_ans;
	int fails;
	int cmp_count;
	// The small-relay variant is fed in parallel so one request checks both.
	mpf_formatter #(.LARGE_RELAY(1'b1)) uut (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
		.word_order_swap_i(swap), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
		.mb_valid_i(mb_valid), .mb_req_i(mb_req),
		.mb_ans_valid_o(mb_ans_valid), .mb_ans_o(mb_ans));
	mpf_formatter #(.LARGE_RELAY(1'b0)) uut_small (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.req_valid_i(req_valid), .req_ready_o(), .req_i(req),
		.word_order_swap_i(swap), .rsp_valid_o(), .rsp_o(rsp_small),
		.mb_valid_i(mb_valid), .mb_req_i(mb_req),
		.mb_ans_valid_o(), .mb_ans_o());
	mpf_host_model host (
		.core_clk_i(core_clk_i), .req_ready_i(req_ready),
		.rsp_valid_i(rsp_valid), .rsp_i(rsp),
		.mb_ans_valid_i(mb_ans_valid), .mb_ans_i(mb_ans),
		.req_valid_o(req_valid), .req_o(req), .word_order_swap_o(swap),
		.mb_valid_o(mb_valid), .mb_req_o(mb_req));
	// Free-running clock with an 8 ns period.
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	// Compares with case equality so an unknown never matches.
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : check
	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim;
		$display("compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// One conversion through the host; the answer lands in rs.
	task automatic cv(input logic w, input mpf_kind_e k,
		input logic [3:0] d, input logic [31:0] r, input logic [15:0] wd,
		input logic s, input logic sw, input logic pk);
		mpf_req_s q;
		q = '{wr: w, kind: k, digit: d, pct_ok: pk, word_sel: s, raw: r,
			pct: r, word: wd};
		host.xfer(q, sw, rs, ok);
		check("answered", 32'(ok), 32'h1);
		// A new request is refused while the answer is on show.
		check("refused", 32'(req_ready), 32'h0);
	endtask : cv
	// Scaled reads around both limits and for every offset class.
	task automatic t_numeric;
		logic [3:0] dg [10] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h7, 4'h6, 4'h1,
			4'h5, 4'h9, 4'h8};
		logic [31:0] rw [10] = '{32'h01312d00, 32'h013130e8, 32'hfececf18,
			32'h4d2, 32'h3034, 32'h1e208, 32'hbc4b20, 32'hbebc200, 32'h3034,
			32'hffffb1e0};
		logic [15:0] ex [10] = '{16'h4e20, SAT_HI, SAT_LO, 16'h4d2, 16'h4d2,
			16'h4d2, 16'h4d2, 16'h2, 16'h4d2, 16'hb1e0};
		for (int i = 0; i < 10; i++) begin
			cv(1'b0, K_NUM, dg[i], rw[i], 16'h0, 1'b0, 1'b0, 1'b1);
			check("num", 32'(rs.word), 32'(ex[i]));
		end
		cv(1'b0, K_NUM, DIGIT_PCT, 32'h3034, 16'h0, 1'b0, 1'b0, 1'b0);
		check("no_pct", 32'(rs.word), 32'(INVALID_CODE));
		// Offset digits above nine have no meaning and are refused.
		cv(1'b0, K_NUM, 4'ha, 32'h4d2, 16'h0, 1'b0, 1'b0, 1'b1);
		check("bad_digit", 32'(rs.word), 32'(INVALID_CODE));
		cv(1'b0, K_NOVAL, 4'h8, 32'h0, 16'h0, 1'b0, 1'b0, 1'b1);
		check("noval", 32'(rs.word), 32'(INVALID_CODE));
		// A saturated read is asked again with one decimal fewer.
		cv(1'b0, K_NUM, 4'h8, 32'h4e21, 16'h0, 1'b0, 1'b0, 1'b1);
		check("sat", 32'(rs.word), 32'(SAT_HI));
		cv(1'b0, K_NUM, 4'h7, 32'h4e21, 16'h0, 1'b0, 1'b0, 1'b1);
		check("retry", 32'(rs.word), 32'h7d0);
	endtask : t_numeric
	// Writes scale up; the last one overflows 32 bits and is clipped.
	task automatic t_write;
		logic [3:0] dg [4] = '{4'h8, 4'h7, 4'h0, 4'h5};
		logic [15:0] wd [4] = '{16'h4d2, 16'h4d2, 16'h5, 16'h7530};
		logic [31:0] ev [4] = '{32'h4d2, 32'h3034, 32'h1388, 32'h7fffffff};
		for (int i = 0; i < 4; i++) begin
			cv(1'b1, K_NUM, dg[i], 32'h0, wd[i], 1'b0, 1'b0, 1'b1);
			check("wr_val", rs.value, ev[i]);
			check("wr_err", 32'(rs.err), 32'(i == 3));
		end
	endtask : t_write
	// Both halves of a 32-bit value under both word orders, and bit order.
	task automatic t_u32;
		logic [31:0] ev;
		for (int i = 0; i < 4; i++) begin
			cv(1'b0, K_U32, 4'h0, 32'h12345678, 16'h0, i[0], i[1], 1'b1);
			ev = (i[0] ^ i[1]) ? 32'h5678 : 32'h1234;
			check("u32", 32'(rs.word), ev);
		end
		cv(1'b1, K_U32, 4'h0, 32'h12345678, 16'habcd, 1'b1, 1'b0, 1'b1);
		check("u32_wr", rs.value, 32'h1234abcd);
		cv(1'b0, K_BITS, 4'h0, 32'h8001, 16'h0, 1'b0, 1'b0, 1'b1);
		check("bits", 32'(rs.word), 32'h8001);
	endtask : t_u32
	// Split pairs: -5:10 and the -128:-128 corner read, 3:-2 written.
	task automatic t_split;
		cv(1'b0, K_SPLIT, 4'h0, 32'hfb0a, 16'h0, 1'b0, 1'b0, 1'b1);
		check("split_rd", 32'(rs.word), 32'h7b8a);
		cv(1'b0, K_SPLIT, 4'h0, 32'h8080, 16'h0, 1'b0, 1'b0, 1'b1);
		check("split_min", 32'(rs.word), 32'h0);
		cv(1'b1, K_SPLIT, 4'h0, 32'h0, 16'h837e, 1'b0, 1'b0, 1'b1);
		check("split_wr", 32'(rs.value[15:0]), 32'h03fe);
	endtask : t_split
	// Every text code, the special kinds, and a refused text write.
	task automatic t_text;
		mpf_kind_e kd [3] = '{K_NOEXIST, K_DASHED, K_UNSET};
		logic [15:0] ex [3] = '{16'h7533, 16'h7532, 16'h753f};
		for (int i = 0; i < 15; i++) begin
			cv(1'b0, K_TEXT, 4'h0, 32'(i), 16'h0, 1'b0, 1'b0, 1'b1);
			check("text", 32'(rs.word), 32'(TXT_BASE) + 32'(i));
		end
		for (int i = 0; i < 3; i++) begin
			cv(1'b0, kd[i], 4'h0, 32'h0, 16'h0, 1'b0, 1'b0, 1'b1);
			check("special", 32'(rs.word), 32'(ex[i]));
		end
		cv(1'b1, K_TEXT, 4'h0, 32'h0, 16'h753e, 1'b0, 1'b0, 1'b1);
		check("txt_wr", {rs.value[30:0], rs.err}, 32'h1c);
		cv(1'b1, K_TEXT, 4'h0, 32'h0, 16'h753f, 1'b0, 1'b0, 1'b1);
		check("txt_bad", 32'(rs.err), 32'h1);
	endtask : t_text
	// Every relay code on both variants, then an undefined code.
	task automatic t_relay;
		mpf_relay_e rf;
		logic [31:0] ev;
		rf = rf.first();
		repeat (rf.num()) begin
			cv(1'b0, K_RELAY, 4'h0, 32'(rf), 16'h0, 1'b0, 1'b0, 1'b1);
			check("relay", 32'(rs.word), 32'(rf));
			ev = (rf inside {RF_OFF, RF_LEVEL, RF_LOLO, RF_LO, RF_HI, RF_HIHI,
				RF_LOE, RF_CABLE, RF_FIX_AST, RF_ALT_AST, RF_COMM}) ?
				32'(rf) : 32'(INVALID_CODE);
			check("relay_s", 32'(rsp_small.word), ev);
			rf = rf.next();
		end
		cv(1'b0, K_RELAY, 4'h0, 32'h7, 16'h0, 1'b0, 1'b0, 1'b1);
		check("relay_bad", 32'(rs.word), 32'(INVALID_CODE));
		// A flush-valve write is legal only on the large variant.
		cv(1'b1, K_RELAY, 4'h0, 32'h0, 16'h0041, 1'b0, 1'b0, 1'b1);
		check("relay_wr", {rs.value[30:0], rs.err}, 32'h82);
		check("relay_wr_s", 32'(rsp_small.err), 32'h1);
		cv(1'b1, K_RELAY, 4'h0, 32'h0, 16'h0007, 1'b0, 1'b0, 1'b1);
		check("relay_wr_bad", 32'(rs.err), 32'h1);
	endtask : t_relay
	// Back-to-back frames covering each answer and the priority order.
	task automatic t_modbus;
		mpf_mb_req_s fr [9] = '{11'h01c, 11'h41c, 11'h40c, 11'h40e, 11'h40f,
			11'h413, 11'h41b, 11'h443, 11'h403};
		mpf_mb_ans_s ex [9] = '{10'h000, 10'h201, 10'h202, 10'h203, 10'h100,
			10'h100, 10'h100, 10'h100, 10'h201};
		mpf_mb_ans_s a;
		@(negedge core_clk_i);
		for (int i = 0; i < 9; i++) begin
			host.frame(fr[i], i == 8, a, ok);
			check("mb_ok", 32'(ok), 32'h1);
			check("mb_ans", 32'(a), 32'(ex[i]));
		end
		@(negedge core_clk_i);
		check("mb_idle", 32'(mb_ans_valid), 32'h0);
	endtask : t_modbus
	// Reset for 8 cycles, then every scenario in turn.
	initial begin
		sys_rst_i = 1'b1;
		fails = 0;
		cmp_count = 0;
		repeat (8) @(negedge core_clk_i);
		check("rst_ready", 32'(req_ready), 32'h1);
		check("rst_rsp", 32'({rsp_valid, mb_ans_valid}), 32'h0);
		check("rst_word", 32'(rsp.word), 32'h0);
		sys_rst_i = 1'b0;
		t_numeric();
		t_write();
		t_u32();
		t_split();
		t_text();
		t_relay();
		t_modbus();
		end_sim();
	end
	// About 75 transfers and 9 frames, each of at most 20 cycles, fit well inside this.
	initial begin
		#(8 * 5000);
		fails++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
